// ==== include/spi_slave_pkg.sv ====
// Package holding register map, field positions and carrier types of the SPI slave port
package spi_slave_pkg;
	// Register offsets (printed offsets are register indices, not byte addresses: byte address is four times index)
	localparam logic [7:0]  CONFIG_INDEX     = 8'hBC;
	localparam logic [7:0]  STATUS_INDEX     = 8'hBE;
	localparam logic [7:0]  DATA_INDEX       = 8'hBF;
	localparam logic [11:0] CONFIG_ADDR      = {2'h0, CONFIG_INDEX, 2'h0};
	localparam logic [11:0] STATUS_ADDR      = {2'h0, STATUS_INDEX, 2'h0};
	localparam logic [11:0] DATA_ADDR        = {2'h0, DATA_INDEX, 2'h0};
	// Reset values
	localparam logic [7:0]  CONFIG_RESET     = 8'h70;
	localparam logic [7:0]  STATUS_RESET     = 8'h00;
	localparam logic [7:0]  DATA_RESET       = 8'h00;
	// Configuration field positions
	localparam int          CFG_ENABLE_BIT   = 0;
	localparam int          CFG_PHASE_BIT    = 1;
	localparam int          CFG_POLARITY_BIT = 2;
	localparam int          CFG_LSB_BIT      = 3;
	localparam int          CFG_MDONE_BIT    = 4;
	localparam int          CFG_MFALL_BIT    = 5;
	localparam int          CFG_MRISE_BIT    = 6;
	localparam logic [7:0]  CONFIG_WMASK     = 8'h7F;
	// Status field positions
	localparam int          STAT_DONE_BIT    = 0;
	localparam int          STAT_FALL_BIT    = 4;
	localparam int          STAT_RISE_BIT    = 5;
	// AXI response codes
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	// Transmit chain depth
	localparam int          TX_DEPTH         = 2;
	localparam logic [2:0]  BIT_LAST         = 3'h7;

	// Decoded configuration
	typedef struct packed {
		logic mask_select_rise_irq;
		logic mask_select_fall_irq;
		logic mask_transaction_done_irq;
		logic bit_order_lsb_first;
		logic clock_polarity_sel;
		logic clock_phase_sel;
		logic slave_enable;
	} config_s;

	// Events from the serial engine
	typedef struct packed {
		logic select_rise;
		logic select_fall;
		logic byte_done;
		logic tx_pop;
	} link_event_s;
endpackage

// ==== rtl/spi_slave_shifter.sv ====
// Serial engine: synchronises the SPI pins, finds clock edges and shifts bytes
`timescale 1ns/1ps
module spi_slave_shifter (
	input  wire logic                        i_clk,
	input  wire logic                        i_reset_n,
	input  wire spi_slave_pkg::config_s      i_cfg,
	input  wire logic [7:0]                  i_tx_byte,
	input  wire logic                        i_tx_valid,
	input  wire logic                        i_select_n,
	input  wire logic                        i_sclk,
	input  wire logic                        i_mosi,
	output logic [7:0]                       o_rx_byte,
	output spi_slave_pkg::link_event_s       o_event,
	output logic                             o_miso,
	output logic                             o_miso_oe
);
	logic [2:0] cs_sync_reg;
	logic [2:0] ck_sync_reg;
	logic [1:0] mosi_sync_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] rx_shift_reg;
	logic [2:0] bit_cnt_reg;
	logic       loaded_reg;
	logic       cs_low;
	logic       lead_edge;
	logic       trail_edge;
	logic       sample_edge;
	logic       shift_edge;
	logic       ck_act_now;
	logic       ck_act_old;
	logic       rx_in;
	logic [7:0] rx_next;

	// Two flops per pin; third stage of clock and select only feeds edge detection
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cs_sync_reg   <= 3'h7;
			ck_sync_reg   <= 3'h0;
			mosi_sync_reg <= 2'h0;
		end else begin
			cs_sync_reg   <= {cs_sync_reg[1:0], i_select_n};
			ck_sync_reg   <= {ck_sync_reg[1:0], i_sclk};
			mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
		end
	end

	// Polarity folds the clock to active level; phase picks which edge samples
	assign cs_low      = ~cs_sync_reg[1];
	assign ck_act_now  = ck_sync_reg[1] ^ i_cfg.clock_polarity_sel;
	assign ck_act_old  = ck_sync_reg[2] ^ i_cfg.clock_polarity_sel;
	assign lead_edge   = cs_low & i_cfg.slave_enable & ck_act_now & ~ck_act_old;
	assign trail_edge  = cs_low & i_cfg.slave_enable & ~ck_act_now & ck_act_old;
	assign sample_edge = i_cfg.clock_phase_sel ? trail_edge : lead_edge;
	assign shift_edge  = i_cfg.clock_phase_sel ? lead_edge : trail_edge;
	assign rx_in       = mosi_sync_reg[1];
	assign rx_next     = i_cfg.bit_order_lsb_first ? {rx_in, rx_shift_reg[7:1]}
	                                               : {rx_shift_reg[6:0], rx_in};

	// Select edges, gated by enable since the core stands still when disabled
	assign o_event.select_fall = i_cfg.slave_enable & cs_sync_reg[2] & ~cs_sync_reg[1];
	assign o_event.select_rise = i_cfg.slave_enable & ~cs_sync_reg[2] & cs_sync_reg[1];
	assign o_event.byte_done   = sample_edge & (bit_cnt_reg == spi_slave_pkg::BIT_LAST);
	assign o_event.tx_pop      = ~loaded_reg & i_tx_valid & cs_low & i_cfg.slave_enable;

	// Bit counter restarts at every select assertion
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bit_cnt_reg <= 3'h0;
		end else if (o_event.select_fall || !cs_low) begin
			bit_cnt_reg <= 3'h0;
		end else if (sample_edge) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	// Receive shifter; completed byte captured for the data register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_shift_reg <= 8'h00;
			o_rx_byte    <= 8'h00;
		end else if (sample_edge) begin
			rx_shift_reg <= rx_next;
			if (bit_cnt_reg == spi_slave_pkg::BIT_LAST) begin
				o_rx_byte <= rx_next;
			end
		end
	end

	// Transmit shifter loads from the chain head; the first bit sits on the line
	// before any clock so the exchange is full duplex from the first edge
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_shift_reg <= 8'h00;
			loaded_reg   <= 1'b0;
		end else if (!cs_low) begin
			loaded_reg <= 1'b0;
		end else if (o_event.tx_pop) begin
			tx_shift_reg <= i_tx_byte;
			loaded_reg   <= 1'b1;
		end else if (shift_edge && bit_cnt_reg != 3'h0) begin
			tx_shift_reg <= i_cfg.bit_order_lsb_first ? {1'b0, tx_shift_reg[7:1]}
			                                          : {tx_shift_reg[6:0], 1'b0};
		end else if (o_event.byte_done) begin
			loaded_reg <= 1'b0; // Next byte taken from the chain right after
		end
	end

	// Output pin released while not selected
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_miso    <= 1'b0;
			o_miso_oe <= 1'b0;
		end else begin
			o_miso    <= i_cfg.bit_order_lsb_first ? tx_shift_reg[0] : tx_shift_reg[7];
			o_miso_oe <= cs_low & i_cfg.slave_enable;
		end
	end

	a_oe_follows_cs: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!cs_low |=> !o_miso_oe) else $error("miso driven while deselected");
	a_cnt_cleared: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_event.select_fall |=> bit_cnt_reg == 3'h0) else $error("counter not reset");
	a_no_edge_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_cfg.slave_enable |-> !sample_edge && !shift_edge) else $error("edge while off");
	a_order_msb: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		sample_edge && !i_cfg.bit_order_lsb_first |=> rx_shift_reg[0] == $past(rx_in))
		else $error("msb first receive wrong");
	a_sample_phase: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		sample_edge |-> (i_cfg.clock_phase_sel ? trail_edge : lead_edge))
		else $error("sample edge wrong");
endmodule

// ==== rtl/spi_slave_port.sv ====
// SPI slave port top: AXI4-Lite registers, transmit chain and status flags
//
// Function
// - Configuration bit 0 enables the slave; disabled core stands still.
// - Configuration bit 6 masks select-rise interrupt, resets to one.
// - Configuration bit 5 masks select-fall interrupt, resets to one.
// - Configuration bit 4 masks transaction-done interrupt, resets to one.
// - Configuration bit 3 chooses LSB first when set, MSB first otherwise.
// - Configuration bit 2 sets clock polarity; one means clock active low.
// - Configuration bit 1 selects trailing-edge sampling when set.
// - All four SPI modes come from polarity and phase combined.
// - Status bit 5 sets on select rise, clears on status read.
// - Status bit 4 sets on select fall, clears on status read.
// - Status bit 0 sets on transaction done, clears on status read.
// - Three maskable sources; status register tells which fired.
// - Data register writes transmit chain, reads receive byte.
// - Chain holds two preloaded bytes; only one before select falls.
// - First preloaded byte shifts out while master byte shifts in.
`timescale 1ns/1ps
module spi_slave_port (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RESET_N,
	// AXI4-Lite write address
	input  wire logic [11:0] I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	// AXI4-Lite write response
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	// AXI4-Lite read address
	input  wire logic [11:0] I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	// AXI4-Lite read data
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	// SPI pins
	input  wire logic        I_SLAVE_SELECT_N,
	input  wire logic        I_SLAVE_SERIAL_CLOCK,
	input  wire logic        I_SLAVE_DATA_IN,
	output logic             O_SLAVE_DATA_OUT,
	output logic             O_SLAVE_DATA_OUT_OE,
	// Interrupt request
	output logic             O_IRQ
);
	logic [7:0]                 config_reg;
	logic [7:0]                 status_reg;
	logic [7:0]                 status_next;
	logic [7:0]                 tx_chain_reg [spi_slave_pkg::TX_DEPTH];
	logic [1:0]                 tx_count_reg;
	logic [11:0]                awaddr_reg;
	logic                       aw_held_reg;
	logic [31:0]                wdata_reg;
	logic [3:0]                 wstrb_reg;
	logic                       w_held_reg;
	logic                       wr_fire;
	logic                       rd_fire;
	logic                       wr_hit;
	logic                       rd_hit;
	logic                       data_write;
	logic                       status_read;
	logic                       tx_accept;
	logic                       select_low;
	logic [1:0]                 sel_sync_reg;
	logic [7:0]                 rx_byte;
	logic [7:0]                 rd_value;
	spi_slave_pkg::config_s     cfg;
	spi_slave_pkg::link_event_s link_ev;

	// Register address decode, shared by both paths
	function automatic logic addr_mapped(input logic [11:0] addr);
		addr_mapped = (addr == spi_slave_pkg::CONFIG_ADDR) || (addr == spi_slave_pkg::STATUS_ADDR)
		           || (addr == spi_slave_pkg::DATA_ADDR);
	endfunction

	// Configuration fields as a carrier
	assign cfg = '{
		mask_select_rise_irq:      config_reg[spi_slave_pkg::CFG_MRISE_BIT],
		mask_select_fall_irq:      config_reg[spi_slave_pkg::CFG_MFALL_BIT],
		mask_transaction_done_irq: config_reg[spi_slave_pkg::CFG_MDONE_BIT],
		bit_order_lsb_first:       config_reg[spi_slave_pkg::CFG_LSB_BIT],
		clock_polarity_sel:        config_reg[spi_slave_pkg::CFG_POLARITY_BIT],
		clock_phase_sel:           config_reg[spi_slave_pkg::CFG_PHASE_BIT],
		slave_enable:              config_reg[spi_slave_pkg::CFG_ENABLE_BIT]
	};

	// Write channels are taken independently and held until both are present
	assign O_AWREADY = ~aw_held_reg & ~O_BVALID;
	assign O_WREADY  = ~w_held_reg & ~O_BVALID;
	assign wr_fire   = aw_held_reg & w_held_reg & ~O_BVALID;
	assign wr_hit    = addr_mapped(awaddr_reg);

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			awaddr_reg  <= 12'h000;
			aw_held_reg <= 1'b0;
		end else if (I_AWVALID && O_AWREADY) begin
			awaddr_reg  <= I_AWADDR;
			aw_held_reg <= 1'b1;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
			w_held_reg <= 1'b0;
		end else if (I_WVALID && O_WREADY) begin
			wdata_reg  <= I_WDATA;
			wstrb_reg  <= I_WSTRB;
			w_held_reg <= 1'b1;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	// Write response: unmapped addresses answer with a slave error
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_BVALID <= 1'b0;
			O_BRESP  <= spi_slave_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			O_BVALID <= 1'b1;
			O_BRESP  <= wr_hit ? spi_slave_pkg::RESP_OKAY : spi_slave_pkg::RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// Configuration register; only the low byte lane carries data
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			config_reg <= spi_slave_pkg::CONFIG_RESET;
		end else if (wr_fire && wstrb_reg[0] && awaddr_reg == spi_slave_pkg::CONFIG_ADDR) begin
			config_reg <= wdata_reg[7:0] & spi_slave_pkg::CONFIG_WMASK;
		end
	end

	// Transmit chain: two places; a full chain drops further writes.
	// Before select falls only one place is offered, so the shifter can grab it
	// and a second write then lands behind it.
	// Select pin passes two flops before the chain logic reads it
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			sel_sync_reg <= 2'h3;
		end else begin
			sel_sync_reg <= {sel_sync_reg[0], I_SLAVE_SELECT_N};
		end
	end

	assign select_low = link_ev.select_fall | (cfg.slave_enable & ~sel_sync_reg[1]);
	assign data_write = wr_fire && wstrb_reg[0] && awaddr_reg == spi_slave_pkg::DATA_ADDR;
	assign tx_accept  = data_write && (tx_count_reg < 2'(spi_slave_pkg::TX_DEPTH))
	                    && (select_low || tx_count_reg == 2'h0);

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tx_count_reg    <= 2'h0;
			tx_chain_reg[0] <= spi_slave_pkg::DATA_RESET;
			tx_chain_reg[1] <= spi_slave_pkg::DATA_RESET;
		end else if (link_ev.tx_pop) begin
			tx_chain_reg[0] <= tx_accept && tx_count_reg == 2'h1 ? wdata_reg[7:0]
			                                                      : tx_chain_reg[1];
			if (tx_accept && tx_count_reg == 2'h2) begin
				tx_chain_reg[1] <= wdata_reg[7:0];
			end
			tx_count_reg <= tx_accept ? tx_count_reg : tx_count_reg - 2'h1;
		end else if (tx_accept) begin
			tx_chain_reg[tx_count_reg[0]] <= wdata_reg[7:0];
			tx_count_reg                  <= tx_count_reg + 2'h1;
		end
	end

	// Sticky status; a new event wins over the clear of the same read
	assign status_read = rd_fire && I_ARADDR == spi_slave_pkg::STATUS_ADDR;
	always_comb begin
		status_next = status_read ? 8'h00 : status_reg;
		if (link_ev.select_rise) begin
			status_next[spi_slave_pkg::STAT_RISE_BIT] = 1'b1;
		end
		if (link_ev.select_fall) begin
			status_next[spi_slave_pkg::STAT_FALL_BIT] = 1'b1;
		end
		if (link_ev.byte_done) begin
			status_next[spi_slave_pkg::STAT_DONE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			status_reg <= spi_slave_pkg::STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// Interrupt request from unmasked sources, registered
	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= (status_next[spi_slave_pkg::STAT_RISE_BIT] & ~cfg.mask_select_rise_irq)
			       | (status_next[spi_slave_pkg::STAT_FALL_BIT] & ~cfg.mask_select_fall_irq)
			       | (status_next[spi_slave_pkg::STAT_DONE_BIT]
			          & ~cfg.mask_transaction_done_irq);
		end
	end

	// Read path: one-cycle answer held until taken
	assign O_ARREADY = ~O_RVALID;
	assign rd_fire   = I_ARVALID & O_ARREADY;
	assign rd_hit    = addr_mapped(I_ARADDR);
	always_comb begin
		rd_value = 8'h00;
		if (I_ARADDR == spi_slave_pkg::CONFIG_ADDR) begin
			rd_value = config_reg;
		end else if (I_ARADDR == spi_slave_pkg::STATUS_ADDR) begin
			rd_value = status_reg;
		end else if (I_ARADDR == spi_slave_pkg::DATA_ADDR) begin
			rd_value = rx_byte;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RVALID <= 1'b0;
			O_RDATA  <= 32'h0000_0000;
			O_RRESP  <= spi_slave_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			O_RVALID <= 1'b1;
			O_RDATA  <= {24'h00_0000, rd_value};
			O_RRESP  <= rd_hit ? spi_slave_pkg::RESP_OKAY : spi_slave_pkg::RESP_SLVERR;
		end else if (I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end

	// Serial engine
	spi_slave_shifter u_shifter (
		.i_clk      (I_SYS_CLK),
		.i_reset_n  (I_RESET_N),
		.i_cfg      (cfg),
		.i_tx_byte  (tx_chain_reg[0]),
		.i_tx_valid (tx_count_reg != 2'h0),
		.i_select_n (I_SLAVE_SELECT_N),
		.i_sclk     (I_SLAVE_SERIAL_CLOCK),
		.i_mosi     (I_SLAVE_DATA_IN),
		.o_rx_byte  (rx_byte),
		.o_event    (link_ev),
		.o_miso     (O_SLAVE_DATA_OUT),
		.o_miso_oe  (O_SLAVE_DATA_OUT_OE)
	);

	a_rise_sticks: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		link_ev.select_rise |=> status_reg[spi_slave_pkg::STAT_RISE_BIT])
		else $error("select rise flag lost");
	a_fall_sticks: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		link_ev.select_fall |=> status_reg[spi_slave_pkg::STAT_FALL_BIT])
		else $error("select fall flag lost");
	a_done_sticks: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		link_ev.byte_done |=> status_reg[spi_slave_pkg::STAT_DONE_BIT])
		else $error("done flag lost");
	a_read_clears: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		status_read && !link_ev.byte_done |=> !status_reg[spi_slave_pkg::STAT_DONE_BIT])
		else $error("status not cleared by read");
	a_irq_masked: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		(config_reg[6:4] == 3'h7) |=> !O_IRQ) else $error("irq with all masked");
	a_irq_done: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		status_reg[spi_slave_pkg::STAT_DONE_BIT] && !cfg.mask_transaction_done_irq
		&& !status_read |=> O_IRQ) else $error("irq missing");
	a_chain_bound: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		tx_count_reg <= 2'(spi_slave_pkg::TX_DEPTH)) else $error("chain overflow");
	a_one_preload: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		data_write && !select_low && tx_count_reg != 2'h0 |=> tx_count_reg == $past(tx_count_reg))
		else $error("second preload before select");
	a_write_answer: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		wr_fire |=> O_BVALID) else $error("write response missing");
	a_bresp_holds: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped");
	a_read_answer: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		rd_fire |=> O_RVALID) else $error("read response missing");
	a_rdata_holds: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped");
	a_pop_drains: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
		link_ev.tx_pop && !tx_accept |=> tx_count_reg == $past(tx_count_reg) - 2'h1)
		else $error("chain not drained by pop");
endmodule

// ==== test/spi_master_model.sv ====
// Behavioural SPI master that frames bytes toward the slave port
`timescale 1ns/1ps
module spi_master_model (
	input  wire logic i_miso,
	input  wire logic i_miso_oe,
	output logic      o_select_n,
	output logic      o_sclk,
	output logic      o_mosi
);
	logic pha;
	// Idle: deselected, clock parked, data line parked
	initial begin
		o_select_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		pha = 1'b0;
	end
	// Clock parks at the idle level of the mode before select falls
	task automatic open_frame(input logic [1:0] mode);
		pha = mode[0];
		o_sclk = mode[1];
		#40 o_select_n = 1'b0;
		#64;
	endtask
	// Data set on the shift edge, slave data taken on the sample edge
	// A released slave line reads the inverse of its last level, so it never passes by luck
	task automatic shift(input logic [7:0] tx, input logic lsb, input int n,
		output logic [7:0] rx);
		int b;
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			b = lsb ? i : 7 - i;
			if (!pha) o_mosi = tx[b];
			#32 o_sclk = ~o_sclk;
			if (pha) o_mosi = tx[b];
			else rx[b] = i_miso_oe ? i_miso : ~i_miso;
			#32 o_sclk = ~o_sclk;
			if (pha) rx[b] = i_miso_oe ? i_miso : ~i_miso;
		end
		#32;
	endtask
	// Release: select rises and the data line shows the inverse of its last bit
	task automatic close_frame();
		o_select_n = 1'b1;
		o_mosi = ~o_mosi;
		#64;
	endtask
endmodule

// ==== test/test_spi_slave_port.sv ====
// Testbench of the SPI slave port: register bus tasks, transfer table and corner cases
`timescale 1ns/1ps
module test_spi_slave_port;
	localparam logic [11:0] CA = spi_slave_pkg::CONFIG_ADDR;
	localparam logic [11:0] SA = spi_slave_pkg::STATUS_ADDR;
	localparam logic [11:0] DA = spi_slave_pkg::DATA_ADDR;
	typedef struct packed { logic [7:0] cfg; logic [7:0] tx; logic [7:0] mo; } row_s;
	// Every mode in both bit orders, with varied interrupt masks
	localparam row_s ROWS [8] = '{'{8'h71, 8'hA5, 8'h3C}, '{8'h03, 8'h96, 8'hC3},
		'{8'h65, 8'h81, 8'h7E}, '{8'h57, 8'h4D, 8'hB2}, '{8'h39, 8'hE1, 8'h1E},
		'{8'h7B, 8'h0F, 8'hF0}, '{8'h0D, 8'h6C, 8'h35}, '{8'h7F, 8'hD2, 8'h4B}};
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        sel_n, sclk, mosi, miso, miso_oe, irq, awready, wready, bvalid, arready;
	logic        rvalid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdat, rd;
	logic [1:0]  resp, bresp, rresp;
	logic [7:0]  rx;
	int          failures, cmp_count, cyc;

	spi_slave_port dut_u (
		.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
		.I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdat),
		.O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_SLAVE_SELECT_N(sel_n),
		.I_SLAVE_SERIAL_CLOCK(sclk), .I_SLAVE_DATA_IN(mosi), .O_SLAVE_DATA_OUT(miso),
		.O_SLAVE_DATA_OUT_OE(miso_oe), .O_IRQ(irq));
	spi_master_model mst_u (.i_miso(miso), .i_miso_oe(miso_oe), .o_select_n(sel_n),
		.o_sclk(sclk), .o_mosi(mosi));

	// Clock, and a ceiling on run length so a hung handshake still ends the run
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			failures++;
			results();
		end
	end
	// Compare and count; an unknown never matches
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic axw(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask
	// Read: address held until taken, data taken at the valid edge
	task automatic axr(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdat;
		resp = rresp;
	endtask
	// One byte, or its first n bits, on the link, started off the system clock edge
	task automatic xb(input logic [7:0] tx, input logic lsb, input int n);
		@(posedge clk);
		#1 mst_u.shift(tx, lsb, n, rx);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Reset, table of transfers, then preload, abort and disable cases
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 56'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		check("irq reset", irq, 1'b0);
		check("oe reset", miso_oe, 1'b0);
		axr(CA);
		check("config reset", rd, 32'h70);
		axr(SA);
		check("status reset", rd, 32'h00);
		axr(12'h000);
		check("unmapped resp", resp, spi_slave_pkg::RESP_SLVERR);
		axw(CA, 8'hFF);
		axr(CA);
		check("config rw", rd, 32'h7F);
		$display("test reset done");
		foreach (ROWS[k]) begin
			axw(CA, ROWS[k].cfg);
			axw(DA, ROWS[k].tx);
			@(posedge clk);
			#1 mst_u.open_frame(ROWS[k].cfg[2:1]);
			xb(ROWS[k].mo, ROWS[k].cfg[3], 8);
			mst_u.close_frame();
			check("miso byte", rx, ROWS[k].tx);
			check("irq set", irq, ROWS[k].cfg[6:4] != 3'h7);
			axr(SA);
			check("status", rd, 32'h31);
			repeat (2) @(posedge clk);
			check("irq clear", irq, 1'b0);
			axr(DA);
			check("rx byte", rd, ROWS[k].mo);
		end
		$display("test table done");
		// Second write before select is dropped; refill once after select falls and once after the first byte
		axw(CA, 8'h01);
		axw(DA, 8'h5A);
		axw(DA, 8'hEE);
		@(posedge clk);
		#1 mst_u.open_frame(2'h0);
		axw(DA, 8'hC7);
		xb(8'h11, 1'b0, 8);
		check("first byte", rx, 32'h5A);
		axw(DA, 8'h3E);
		xb(8'h22, 1'b0, 8);
		check("second byte", rx, 32'hC7);
		xb(8'h33, 1'b0, 8);
		check("third byte", rx, 32'h3E);
		mst_u.close_frame();
		axr(DA);
		check("last rx", rd, 32'h33);
		axr(SA);
		$display("test chain done");
		// Frame cut after three bits: no done flag, next frame starts a fresh byte
		@(posedge clk);
		#1 mst_u.open_frame(2'h0);
		xb(8'hFF, 1'b0, 3);
		mst_u.close_frame();
		check("oe released", miso_oe, 1'b0);
		axr(SA);
		check("abort status", rd, 32'h30);
		@(posedge clk);
		#1 mst_u.open_frame(2'h0);
		xb(8'h69, 1'b0, 8);
		mst_u.close_frame();
		axr(DA);
		check("after abort", rd, 32'h69);
		$display("test abort done");
		// Disabled slave: output never driven, no flags raised
		axw(CA, 8'h00);
		axr(SA);
		@(posedge clk);
		#1 mst_u.open_frame(2'h0);
		xb(8'h42, 1'b0, 8);
		mst_u.close_frame();
		check("disabled out", rx, 8'hFF);
		axr(SA);
		check("disabled status", rd, 32'h00);
		$display("test disable done");
		results();
	end
endmodule
